/* shared/uart_sfi_defines.svh */
// Purpose: offsets, field positions, reset values and timing counts of the
//          uart status, fifo-control and interrupt-identification block
// Assumes: byte addresses on a classic wishbone bus, 8-bit data in lane 0
// Notes:   included by the package and by the block
//
// Summary of operation
// - data ready set when character enters buffer
// - data ready clears once buffer fully read
// - overrun on unread overwrite, cleared by status read
// - fifo overrun only when full, character dropped
// - parity error flag, cleared by status read
// - fifo errors travel with character, shown at head
// - framing error on low stop bit unless break, read clears
// - after framing error, low taken as start
// - break when line low over whole character
// - break loads one zero character, waits mark
// - line status interrupt on any error, if enabled
// - holding empty flag follows holding register or fifo
// - transmitter empty when holding and shifter empty
// - top status bit summarises fifo errors
// - fifo enable toggling discards both fifos
// - other control bits need enable written one
// - clear bits empty fifos, self clearing
// - dma mode bit selects pin mode one
// - trigger level 1, 4, 8 or 14
// - prioritised identification codes in low nibble
// - timeout after four idle character times
// - holding empty interrupt cleared by id read or write
// - identification top bits set in fifo mode
// - disabled sources hidden from id and interrupt
`ifndef UART_SFI_DEFINES_SVH
`define UART_SFI_DEFINES_SVH

// register byte offsets
`define SFI_OFS_DATA      8'h00
`define SFI_OFS_IDENT     8'h08
`define SFI_OFS_LSTAT     8'h14

// fifo control field positions
`define SFI_FC_ENABLE     0
`define SFI_FC_RX_CLEAR   1
`define SFI_FC_TX_CLEAR   2
`define SFI_FC_DMA_MODE   3
`define SFI_FC_TRIG_LO    6
`define SFI_FC_TRIG_HI    7

// interrupt enable input positions
`define SFI_IE_RX         0
`define SFI_IE_TX_HOLDING_EMPTY_FLAG       1
`define SFI_IE_LINE       2
`define SFI_IE_MODEM      3

// identification codes
`define SFI_ID_NONE       4'h1
`define SFI_ID_LINE       4'h6
`define SFI_ID_RXDATA     4'h4
`define SFI_ID_TIMEOUT    4'hC
`define SFI_ID_TX_HOLDING_EMPTY_FLAG       4'h2
`define SFI_ID_MODEM      4'h0

// trigger levels in bytes
`define SFI_TRIG_0        5'd1
`define SFI_TRIG_1        5'd4
`define SFI_TRIG_2        5'd8
`define SFI_TRIG_3        5'd14

// reset values and timing
`define SFI_FIFO_DEPTH    16
`define SFI_FC_RESET      8'h00
`define SFI_TICKS_LAST    4'hF
`define SFI_START_MID     4'h7
`define SFI_TIMEOUT_CHARS 4

`endif

/* shared/uart_sfi_pkg.sv */
// Purpose: types shared by the block and its bench
// Assumes: uart_sfi_defines.svh on the include path
// Notes:   bus request and line setup travel as packed structs
package uart_sfi_pkg;
    `include "uart_sfi_defines.svh"

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_PARITY,
        RX_STOP,
        RX_BREAK_WAIT
    } rx_state_e;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_s;

    typedef struct packed {
        logic [1:0] word_len;   // 0..3 gives 5..8 data bits
        logic       parity_en;
        logic       even;
        logic       stick;
        logic       stop2;
    } line_cfg_s;

    typedef struct packed {
        logic       brk;
        logic       frm;
        logic       par;
        logic [7:0] data;
    } rx_entry_s;
endpackage

/* rtl/uart_sfi.sv */
// Purpose: receiver framing, rx/tx fifos, line status, fifo control and
//          prioritised interrupt identification of a uart
// Assumes: i_baud_x16 is a one-cycle pulse at 16x baud on i_clk
// Notes:   interrupt enables and line setup come from registers elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "uart_sfi_defines.svh"

module uart_sfi #(
    parameter int DEPTH = `SFI_FIFO_DEPTH
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_srst,
    input  wire uart_sfi_pkg::wb_req_s i_wb,
    output logic                       o_wb_ack,
    output logic [31:0]                o_wb_dat,
    input  wire logic                  i_serial_input,
    input  wire logic                  i_baud_x16,
    input  wire uart_sfi_pkg::line_cfg_s i_line_cfg,
    input  wire logic [3:0]            i_int_enable,
    input  wire logic                  i_modem_status_int,
    input  wire logic                  i_tx_load,
    input  wire logic                  i_tx_shift_busy,
    output logic                       o_tx_valid,
    output logic [7:0]                 o_tx_data,
    output logic                       o_intr,
    output logic                       o_receive_dma_request_pin_n,
    output logic                       o_transmit_dma_request_pin_n
);
    import uart_sfi_pkg::*;

    localparam int AW = $clog2(DEPTH);

    // trigger levels up to 14 and counters need a power of two
    if (DEPTH < 14 || DEPTH > 16 || (1 << AW) != DEPTH)
        $error("uart_sfi: DEPTH must be 16");

    typedef struct packed {
        logic                     sin_meta;
        logic                     sin_sync;
        rx_state_e                rx_state;
        logic [3:0]               tick;
        logic [3:0]               bitn;
        logic [7:0]               shreg;
        logic                     par_bit;
        logic                     all_zero;
        logic [DEPTH-1:0][10:0]   rx_mem;
        logic [AW-1:0]            rx_wr;
        logic [AW-1:0]            rx_rd;
        logic [AW:0]              rx_cnt;
        logic [AW:0]              err_cnt;
        logic [DEPTH-1:0][7:0]    tx_mem;
        logic [AW-1:0]            tx_wr;
        logic [AW-1:0]            tx_rd;
        logic [AW:0]              tx_cnt;
        logic                     fifo_en;
        logic                     dma_mode;
        logic [1:0]               trig;
        logic                     oe;
        logic                     pe;
        logic                     fe;
        logic                     bi;
        logic                     fifo_err;
        logic                     tx_holding_empty_flag_int;
        logic                     tx_holding_empty_flag_prev;
        logic                     timeout;
        logic [9:0]               to_cnt;
        logic                     ack;
        logic [31:0]              rdat;
        logic                     intr;
        logic                     receive_dma_request_pin_n;
        logic                     transmit_dma_request_pin_n;
        logic                     tx_valid;
        logic [7:0]               tx_data;
    } st_s;

    st_s q;
    st_s n;

    // outputs come straight from the state register
    assign o_wb_ack                     = q.ack;
    assign o_wb_dat                     = q.rdat;
    assign o_tx_valid                   = q.tx_valid;
    assign o_tx_data                    = q.tx_data;
    assign o_intr                       = q.intr;
    assign o_receive_dma_request_pin_n  = q.receive_dma_request_pin_n;
    assign o_transmit_dma_request_pin_n = q.transmit_dma_request_pin_n;

    // identification from current state; disabled sources never show
    function automatic logic [3:0] ident(input st_s s, input logic [3:0] ie,
                                         input logic modem);
        logic [4:0] lvl;
        lvl = 5'd0;
        case (s.trig)
            2'd0:    lvl = `SFI_TRIG_0;
            2'd1:    lvl = `SFI_TRIG_1;
            2'd2:    lvl = `SFI_TRIG_2;
            default: lvl = `SFI_TRIG_3;
        endcase
        if (ie[`SFI_IE_LINE] && (s.oe || s.pe || s.fe || s.bi))
            ident = `SFI_ID_LINE;
        else if (ie[`SFI_IE_RX] && s.fifo_en && 5'(s.rx_cnt) >= lvl)
            ident = `SFI_ID_RXDATA;
        else if (ie[`SFI_IE_RX] && !s.fifo_en && s.rx_cnt != '0)
            ident = `SFI_ID_RXDATA;
        else if (ie[`SFI_IE_RX] && s.timeout)
            ident = `SFI_ID_TIMEOUT;
        else if (ie[`SFI_IE_TX_HOLDING_EMPTY_FLAG] && s.tx_holding_empty_flag_int)
            ident = `SFI_ID_TX_HOLDING_EMPTY_FLAG;
        else if (ie[`SFI_IE_MODEM] && modem)
            ident = `SFI_ID_MODEM;
        else
            ident = `SFI_ID_NONE;
    endfunction

    // next-state logic of the whole block
    always_comb
    begin
        logic       acc;
        logic       rd_data;
        logic       rd_ident;
        logic       rd_lstat;
        logic       wr_data;
        logic       wr_fctl;
        logic       push;
        logic       pop;
        logic       head_new;
        logic       flush;
        logic       transmitter_empty_flag;
        logic [3:0] nbits;
        logic [3:0] id;
        logic [7:0] wd;
        logic [7:0] dalign;
        logic [9:0] to_lim;
        rx_entry_s  ent;
        rx_entry_s  head;
        acc      = 1'b0;
        rd_data  = 1'b0;
        rd_ident = 1'b0;
        rd_lstat = 1'b0;
        wr_data  = 1'b0;
        wr_fctl  = 1'b0;
        push     = 1'b0;
        pop      = 1'b0;
        head_new = 1'b0;
        flush    = 1'b0;
        transmitter_empty_flag     = 1'b0;
        nbits    = 4'd5 + {2'b00, i_line_cfg.word_len};
        id       = ident(q, i_int_enable, i_modem_status_int);
        wd       = i_wb.dat[7:0];
        dalign   = 8'h00;
        ent      = '0;
        head     = '0;
        n        = q;

        // pin passes two flops before the receiver looks at it
        n.sin_meta = i_serial_input;
        n.sin_sync = q.sin_meta;

        // bus decode; one access per request, ack drops the next cycle
        acc   = i_wb.cyc && i_wb.stb && !q.ack;
        n.ack = acc;
        if (acc)
        begin
            n.rdat = 32'h0000_0000;
            case (i_wb.adr)
                `SFI_OFS_DATA:
                begin
                    if (i_wb.we)
                        wr_data = i_wb.sel[0];
                    else
                    begin
                        rd_data = 1'b1;
                        n.rdat  = {24'h00_0000, q.rx_mem[q.rx_rd][7:0]};
                    end
                end
                `SFI_OFS_IDENT:
                begin
                    if (i_wb.we)
                        wr_fctl = i_wb.sel[0];
                    else
                    begin
                        rd_ident = 1'b1;
                        n.rdat   = {24'h00_0000, q.fifo_en, q.fifo_en, 2'b00, id};
                    end
                end
                `SFI_OFS_LSTAT:
                begin
                    if (!i_wb.we)
                    begin
                        rd_lstat = 1'b1;
                        transmitter_empty_flag     = q.tx_cnt == '0 && !i_tx_shift_busy && !q.tx_valid;
                        n.rdat   = {24'h00_0000, q.fifo_en && q.fifo_err,
                                    transmitter_empty_flag, q.tx_cnt == '0, q.bi, q.fe, q.pe, q.oe,
                                    q.rx_cnt != '0};
                    end
                end
                default: n.rdat = 32'h0000_0000;  // unmapped reads zero, writes dropped
            endcase
        end

        // status read clears sticky errors; later sets in this pass win
        if (rd_lstat)
        begin
            n.oe = 1'b0;
            n.pe = 1'b0;
            n.fe = 1'b0;
            n.bi = 1'b0;
        end

        // fifo control write; other bits ignored unless enable written one, enable zero in fifo mode empties both fifos
        if (wr_fctl)
        begin
            if (wd[`SFI_FC_ENABLE])
            begin
                flush      = !q.fifo_en;
                n.fifo_en  = 1'b1;
                n.dma_mode = wd[`SFI_FC_DMA_MODE];
                n.trig     = wd[`SFI_FC_TRIG_HI:`SFI_FC_TRIG_LO];
                if (wd[`SFI_FC_RX_CLEAR] || flush)
                begin
                    n.rx_wr   = '0;
                    n.rx_rd   = '0;
                    n.rx_cnt  = '0;
                    n.err_cnt = '0;
                end
                if (wd[`SFI_FC_TX_CLEAR] || flush)
                begin
                    n.tx_wr  = '0;
                    n.tx_rd  = '0;
                    n.tx_cnt = '0;
                end
            end
            else if (q.fifo_en)
            begin
                n.fifo_en = 1'b0;
                n.rx_wr   = '0;
                n.rx_rd   = '0;
                n.rx_cnt  = '0;
                n.err_cnt = '0;
                n.tx_wr   = '0;
                n.tx_rd   = '0;
                n.tx_cnt  = '0;
            end
        end

        // receiver: 16 ticks per bit, mid-bit sampling
        if (i_baud_x16)
        begin
            n.tick = q.tick + 4'd1;
            case (q.rx_state)
                RX_IDLE:
                begin
                    n.all_zero = 1'b1;
                    n.tick     = 4'h0;
                    if (!q.sin_sync)
                        n.rx_state = RX_START;
                end
                RX_START:
                begin
                    n.all_zero = 1'b1;
                    if (q.tick == `SFI_START_MID)
                    begin
                        n.tick = 4'h0;
                        n.bitn = 4'd0;
                        // glitch shorter than half a bit is a false start
                        n.rx_state = q.sin_sync ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA:
                begin
                    if (q.tick == `SFI_TICKS_LAST)
                    begin
                        n.shreg    = {q.sin_sync, q.shreg[7:1]};
                        n.all_zero = q.all_zero && !q.sin_sync;
                        n.bitn     = q.bitn + 4'd1;
                        if (q.bitn == nbits - 4'd1)
                            n.rx_state = i_line_cfg.parity_en ? RX_PARITY : RX_STOP;
                    end
                end
                RX_PARITY:
                begin
                    if (q.tick == `SFI_TICKS_LAST)
                    begin
                        n.par_bit  = q.sin_sync;
                        n.all_zero = q.all_zero && !q.sin_sync;
                        n.rx_state = RX_STOP;
                    end
                end
                RX_STOP:
                begin
                    if (q.tick == `SFI_TICKS_LAST)
                    begin
                        push = 1'b1;
                        case (i_line_cfg.word_len)
                            2'd0:    dalign = {3'b000, q.shreg[7:3]};
                            2'd1:    dalign = {2'b00, q.shreg[7:2]};
                            2'd2:    dalign = {1'b0, q.shreg[7:1]};
                            default: dalign = q.shreg;
                        endcase
                        ent.data = dalign;
                        if (i_line_cfg.stick)
                            ent.par = i_line_cfg.parity_en && (q.par_bit == i_line_cfg.even);
                        else
                            ent.par = i_line_cfg.parity_en &&
                                      ((^dalign ^ q.par_bit) != !i_line_cfg.even);
                        ent.frm = !q.sin_sync;
                        if (!q.sin_sync && q.all_zero)
                        begin
                            // line low for a whole character: one zero entry only
                            ent        = '0;
                            ent.brk    = 1'b1;
                            n.rx_state = RX_BREAK_WAIT;
                        end
                        else if (!q.sin_sync)
                        begin
                            n.tick     = 4'h0;
                            n.rx_state = RX_START;
                        end
                        else
                            n.rx_state = RX_IDLE;
                    end
                end
                RX_BREAK_WAIT:
                begin
                    n.tick = 4'h0;
                    if (q.sin_sync)
                        n.rx_state = RX_IDLE;
                end
                default: n.rx_state = RX_IDLE;
            endcase
        end

        // receive fifo; character mode keeps a single slot
        pop = rd_data && q.rx_cnt != '0 && !wr_fctl;
        if (pop)
        begin
            n.rx_rd  = q.rx_rd + AW'(1);
            n.rx_cnt = q.rx_cnt - (AW+1)'(1);
            if (q.rx_mem[q.rx_rd][10:8] != 3'b000)
                n.err_cnt = q.err_cnt - (AW+1)'(1);
            head_new = q.rx_cnt > (AW+1)'(1);
        end
        if (push && !q.fifo_en)
        begin
            n.rx_mem[0] = ent;
            n.rx_rd     = '0;
            n.rx_wr     = '0;
            n.rx_cnt    = (AW+1)'(1);
            n.oe        = n.oe || (q.rx_cnt != '0 && !pop);
            n.pe        = n.pe || ent.par;
            n.fe        = n.fe || ent.frm;
            n.bi        = n.bi || ent.brk;
        end
        else if (push && q.rx_cnt == (AW+1)'(DEPTH) && !pop)
            n.oe = 1'b1;
        else if (push)
        begin
            // write pointer after any clear in this pass, so a clear never splits
            n.rx_mem[n.rx_wr] = ent;
            n.rx_wr           = n.rx_wr + AW'(1);
            n.rx_cnt          = n.rx_cnt + (AW+1)'(1);
            if (ent.par || ent.frm || ent.brk)
            begin
                n.err_cnt  = n.err_cnt + (AW+1)'(1);
                n.fifo_err = 1'b1;
            end
            head_new = head_new || n.rx_cnt == (AW+1)'(1);
        end

        // fifo mode shows a character's errors once it reaches the head
        if (q.fifo_en && head_new)
        begin
            head = n.rx_mem[n.rx_rd];
            n.pe = n.pe || head.par;
            n.fe = n.fe || head.frm;
            n.bi = n.bi || head.brk;
        end
        if (rd_lstat && n.err_cnt == '0 && !(push && q.fifo_en && n.fifo_err && !q.fifo_err))
            n.fifo_err = 1'b0;
        if (!n.fifo_en)
            n.fifo_err = 1'b0;

        // character timeout: four character times with no traffic
        to_lim = 10'(`SFI_TIMEOUT_CHARS * 16) *
                 (10'd2 + 10'(nbits) + 10'(i_line_cfg.parity_en) + 10'(i_line_cfg.stop2));
        if (!n.fifo_en || n.rx_cnt == '0 || push || pop)
        begin
            n.to_cnt  = 10'd0;
            n.timeout = 1'b0;
        end
        else if (i_baud_x16 && q.to_cnt != to_lim)
            n.to_cnt = q.to_cnt + 10'd1;
        else if (q.to_cnt == to_lim)
            n.timeout = 1'b1;

        // transmit holding register or fifo
        n.tx_valid = 1'b0;
        if (i_tx_load && q.tx_cnt != '0)
        begin
            n.tx_valid = 1'b1;
            n.tx_data  = q.tx_mem[q.tx_rd];
            n.tx_rd    = q.tx_rd + AW'(1);
            n.tx_cnt   = n.tx_cnt - (AW+1)'(1);
        end
        if (wr_data && !q.fifo_en)
        begin
            n.tx_mem[0] = wd;
            n.tx_rd     = '0;
            n.tx_wr     = '0;
            n.tx_cnt    = (AW+1)'(1);
        end
        else if (wr_data && n.tx_cnt != (AW+1)'(DEPTH))
        begin
            n.tx_mem[q.tx_wr] = wd;
            n.tx_wr           = q.tx_wr + AW'(1);
            n.tx_cnt          = n.tx_cnt + (AW+1)'(1);
        end

        // holding-empty interrupt: edge sets it, id read or write clears
        n.tx_holding_empty_flag_prev = n.tx_cnt == '0;
        if ((rd_ident && id == `SFI_ID_TX_HOLDING_EMPTY_FLAG) || wr_data)
            n.tx_holding_empty_flag_int = 1'b0;
        if (n.tx_holding_empty_flag_prev && !q.tx_holding_empty_flag_prev)
            n.tx_holding_empty_flag_int = 1'b1;

        // pins and interrupt line follow the next state
        n.intr = ident(n, i_int_enable, i_modem_status_int) != `SFI_ID_NONE;
        if (n.fifo_en && n.dma_mode)
        begin
            n.receive_dma_request_pin_n = !(ident(n, 4'b0001, 1'b0) != `SFI_ID_NONE);
            n.transmit_dma_request_pin_n = n.tx_cnt == (AW+1)'(DEPTH);
        end
        else
        begin
            n.receive_dma_request_pin_n = n.rx_cnt == '0;
            n.transmit_dma_request_pin_n = n.tx_cnt != '0;
        end
    end

    // single state register; sync reset to idle, empty, character mode
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            q           <= '0;
            q.sin_meta  <= 1'b1;
            q.sin_sync  <= 1'b1;
            q.rx_state  <= RX_IDLE;
            q.all_zero  <= 1'b1;
            q.tx_holding_empty_flag_prev <= 1'b1;
            q.trig      <= 2'(`SFI_FC_RESET >> `SFI_FC_TRIG_LO);
            q.receive_dma_request_pin_n   <= 1'b1;
            q.transmit_dma_request_pin_n   <= 1'b0;
        end
        else
            q <= n;
    end
endmodule // uart_sfi
`default_nettype wire

/* sim/uart_sfi_chk.sv */
// Purpose: port checks of the uart status block
// Assumes: bus answer one cycle after a taken request
// Notes:   bound into every uart_sfi
`timescale 1ns/1ps
`default_nettype none
module uart_sfi_chk
    import uart_sfi_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_srst,
    input wire wb_req_s     i_wb,
    input wire logic        o_wb_ack,
    input wire logic [31:0] o_wb_dat,
    input wire logic [3:0]  i_int_enable,
    input wire logic        i_tx_load,
    input wire logic        o_tx_valid,
    input wire logic        o_intr
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // bus answer timing and width
    ack_timing_a: assert property (i_wb.cyc && i_wb.stb && !o_wb_ack |=> o_wb_ack) else $error("late ack");
    ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
    upper_zero_a: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0) else $error("upper data");
    unmapped_zero_a: assert property (o_wb_ack && $past(i_wb.adr) == 8'h04 |-> o_wb_dat == 32'h0)
        else $error("unmapped read");
    // identification layout
    id_layout_a: assert property (o_wb_ack && $past(i_wb.adr) == 8'h08 && !$past(i_wb.we) |->
        o_wb_dat[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'hC} && o_wb_dat[5:4] == 2'h0
        && o_wb_dat[7] == o_wb_dat[6]) else $error("bad id");
    tx_cause_a: assert property (o_tx_valid |-> $past(i_tx_load)) else $error("tx without load");
    intr_masked_a: assert property ($past(i_int_enable, 2) == 4'h0 && $past(i_int_enable) == 4'h0
        |-> !o_intr) else $error("masked intr");
    // reset must quiet the outputs, so no disable here
    reset_quiet_a: assert property (disable iff (1'b0) i_srst |=> !o_wb_ack && !o_intr
        && !o_tx_valid) else $error("reset outputs");
endmodule // uart_sfi_chk
bind uart_sfi uart_sfi_chk chk_i (.i_clk(i_clk), .i_srst(i_srst), .i_wb(i_wb),
    .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_int_enable(i_int_enable),
    .i_tx_load(i_tx_load), .o_tx_valid(o_tx_valid), .o_intr(o_intr));
`default_nettype wire

/* sim/uart_sfi_peer.sv */
// Purpose: serial peer sending frames to the receiver
// Assumes: 16 clocks per bit, baud tick tied high
// Notes:   8 data bits, no parity, caller picks stop level
`timescale 1ns/1ps
`default_nettype none
module uart_sfi_peer (
    input  wire logic i_clk,
    output logic      o_line
);
    // line rests at mark outside frames
    initial o_line = 1'b1;
    // lsb first; a low stop lets the bench fake framing and break
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++)
            repeat (16) @(posedge i_clk) o_line <= f[i];
        @(posedge i_clk) o_line <= 1'b1;
    endtask
endmodule // uart_sfi_peer
`default_nettype wire

/* sim/uart_sfi_tb.sv */
// Purpose: self-checking bench of the uart status block
// Assumes: bus answer after one cycle, char in buffer 3 cycles past mid stop bit
// Notes:   8N1 framing, one clock per baud tick
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
module uart_sfi_tb;
    import uart_sfi_pkg::*;
    int          fails = 0;
    int          tests_run = 0;
    logic        clk = 1'b0, srst = 1'b1, ack, intr, txv, serial_input, load = 1'b0, mdm = 1'b0;
    logic        busy = 1'b0, rxr_n, txr_n;
    logic [31:0] rdat;
    logic [7:0]  txd, q;
    logic [3:0]  ien = 4'h0;
    wb_req_s     wbr = '0;
    always #4 clk = ~clk;
    uart_sfi uart_sfi_i (.i_clk(clk), .i_srst(srst), .i_wb(wbr), .o_wb_ack(ack),
        .o_wb_dat(rdat), .i_serial_input(serial_input), .i_baud_x16(1'b1), .i_line_cfg(6'h30),
        .i_int_enable(ien), .i_modem_status_int(mdm), .i_tx_load(load),
        .i_tx_shift_busy(busy), .o_tx_valid(txv), .o_tx_data(txd), .o_intr(intr),
        .o_receive_dma_request_pin_n(rxr_n), .o_transmit_dma_request_pin_n(txr_n));
    uart_sfi_peer uart_sfi_peer_i (.i_clk(clk), .o_line(serial_input));
    task automatic complete_run;
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one classic cycle, held until ack is seen at an edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        wbr <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
        do
            @(posedge clk);
        while (ack !== 1'b1 && ++n < 20);
        if (n >= 20)
        begin
            fails++;
            $display("ERROR %0t bus timeout", $time);
            complete_run();
        end
        q = rdat[7:0];
        wbr <= '0;
        @(posedge clk);
    endtask
    task automatic frame(input logic [7:0] d, input logic stop);
        uart_sfi_peer_i.send(d, stop);
        repeat (4) @(posedge clk);
    endtask
    task automatic mode_switch;
        wb(1, 8'h08, 8'hC1);
        wb(0, 8'h08, 8'h00); `CHK(q[7:6], 2'h3)
        wb(1, 8'h08, 8'h00);
        wb(0, 8'h08, 8'h00); `CHK(q[7:6], 2'h0)
        wb(0, 8'h04, 8'h00); `CHK(q, 8'h00)
        mdm <= 1'b1;
        wb(0, 8'h08, 8'h00); `CHK(q, 8'h01)
        ien <= 4'h8;
        wb(0, 8'h08, 8'h00); `CHK(q, 8'h00)
        ien <= 4'h0;
        mdm <= 1'b0;
    endtask
    task automatic rx_flags;
        frame(8'hA5, 1'b1);
        wb(0, 8'h14, 8'h00); `CHK(q[0], 1'b1)
        wb(0, 8'h00, 8'h00); `CHK(q, 8'hA5)
        wb(0, 8'h14, 8'h00); `CHK(q[1:0], 2'h0)
        frame(8'h11, 1'b1);
        frame(8'h22, 1'b1);
        wb(0, 8'h14, 8'h00); `CHK(q[1], 1'b1)
        wb(0, 8'h14, 8'h00); `CHK(q[1], 1'b0)
        wb(0, 8'h00, 8'h00); `CHK(q, 8'h22)
    endtask
    task automatic line_errors;
        ien <= 4'h4;
        frame(8'h3C, 1'b0); `CHK(intr, 1'b1)
        wb(0, 8'h08, 8'h00); `CHK(q[3:0], 4'h6)
        wb(0, 8'h14, 8'h00); `CHK(q[3], 1'b1)
        wb(0, 8'h00, 8'h00);
        wb(0, 8'h08, 8'h00); `CHK(q[3:0], 4'h1)
        frame(8'h00, 1'b0);
        wb(0, 8'h14, 8'h00); `CHK(q[4], 1'b1)
        wb(0, 8'h00, 8'h00); `CHK(q, 8'h00)
        wb(0, 8'h14, 8'h00); `CHK(q[0], 1'b0)
        ien <= 4'h0;
    endtask
    task automatic tx_path;
        wb(0, 8'h14, 8'h00); `CHK(q[6:5], 2'h3)
        wb(1, 8'h00, 8'h5A);
        wb(0, 8'h14, 8'h00); `CHK(q[6:5], 2'h0)
        `CHK(txr_n, 1'b1)
        ien <= 4'h2;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
        @(posedge clk); `CHK({txv, txd}, 9'h15A)
        wb(0, 8'h08, 8'h00); `CHK(q, 8'h02)
        wb(0, 8'h08, 8'h00); `CHK(q, 8'h01)
        ien <= 4'h0;
        busy <= 1'b1;
        wb(0, 8'h14, 8'h00); `CHK(q[6:5], 2'h1)
        busy <= 1'b0;
    endtask
    // fifo mode, dma mode one, trigger four, then timeout and discard
    task automatic fifo_mode;
        ien <= 4'h1;
        wb(1, 8'h08, 8'h49);
        frame(8'h31, 1'b1);
        frame(8'h32, 1'b0);
        wb(0, 8'h14, 8'h00); `CHK(q, 8'hE1)
        `CHK(rxr_n, 1'b1)
        repeat (700) @(posedge clk);
        `CHK({intr, rxr_n}, 2'b10)
        wb(0, 8'h08, 8'h00); `CHK(q, 8'hCC)
        wb(0, 8'h00, 8'h00); `CHK(q, 8'h31)
        `CHK(intr, 1'b0)
        wb(0, 8'h14, 8'h00); `CHK(q, 8'hE9)
        wb(0, 8'h00, 8'h00); `CHK(q, 8'h32)
        wb(0, 8'h14, 8'h00);
        wb(0, 8'h14, 8'h00); `CHK(q, 8'h60)
        frame(8'h55, 1'b1);
        wb(1, 8'h08, 8'h00);
        wb(0, 8'h14, 8'h00); `CHK(q[0], 1'b0)
        ien <= 4'h0;
    endtask
    // reset, then each scenario in turn
    initial
    begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        mode_switch();
        rx_flags();
        line_errors();
        tx_path();
        fifo_mode();
        complete_run();
    end
endmodule // uart_sfi_tb
`default_nettype wire
